// [hw/urxe_rx.sv]
/*
 Receive side of an asynchronous serial port with overrun detection,
 three-sample noise detection and false start rejection.
 Assumes the transmitter sends 8N1 frames, software access strobes are
 one-cycle pulses on mclk, and the baud divider is set elsewhere.
*/
`timescale 1ns/10ps

// How it works
// RULE1: A frame that completes while rx_full_flag is set is an overrun.
// RULE2: While rx_full_flag is set no new character enters rx_data_holding.
// RULE3: On overrun overrun_flag sets, the held byte stays, the shift reg is overwritten.
// RULE4: Overrun requests the interrupt only with rx_int_enable set and int_mask_bit clear.
// RULE5: overrun_flag clears on a status access then a data read, in that order.
// RULE6: Data bits are judged on samples 8, 9 and 10; disagreement marks noise.
// RULE7: A start bit is clean only with a valid falling edge and three agreeing samples.
// RULE8: noise_flag of a frame appears in the same cycle rx_full_flag rises.
// RULE9: A noisy frame is still delivered to the data register normally.
// RULE10: Noise raises no interrupt by itself; only rx_full_flag or overrun_flag does.
// RULE11: noise_flag clears on a status read then a data read.
// RULE12: Disagreeing start samples discard the frame without receiving it.
// RULE13: A false start sets no rx_full_flag and records noise only internally.
// RULE14: That hidden noise shows with the next valid frame's rx_full_flag.
// RULE15: The line is oversampled sixteen times per bit.
module urxe_rx
(
	// Clock and reset
	input  wire logic                  mclk,
	input  wire logic                  rst_n,
	// Serial line
	input  wire logic                  rx_line,
	// Configuration
	input  wire logic [urxe_pkg::DIV_W-1:0] baud_div_last,
	input  wire logic                  rx_int_enable,
	input  wire logic                  int_mask_bit,
	// Software accesses
	input  wire urxe_pkg::urxe_access_type sw_access,
	// Status and data
	output urxe_pkg::urxe_flags_type   flags,
	output logic [7:0]                 serial_data_reg,
	output logic [7:0]                 shift_reg,
	output logic                       rx_irq
);
	import urxe_pkg::*;

	// ----------------------------------------------------------------
	// Line synchroniser and oversample tick
	// ----------------------------------------------------------------
	logic line_s;
	logic tick;

	// Only the second flop of the synchroniser feeds the sampler
	urxe_sync u_sync
	(
		.mclk (mclk),
		.rst_n(rst_n),
		.din  (rx_line),
		.dout (line_s)
	);

	// Divider comes from this clock domain, so it needs no synchroniser
	urxe_tick u_tick
	(
		.mclk    (mclk),
		.rst_n   (rst_n),
		.div_last(baud_div_last),
		.tick    (tick)
	);

	// ----------------------------------------------------------------
	// Bit sampler
	// ----------------------------------------------------------------
	urxe_state_type   state_reg;
	urxe_state_type   state_next;
	logic [3:0]       smp_reg;
	logic [3:0]       smp_next;
	logic [3:0]       bit_reg;
	logic [3:0]       bit_next;
	logic [2:0]       vote_reg;
	logic [2:0]       vote_next;
	logic             prev_reg;
	logic             prev_next;
	// Two line samples back, to qualify the start edge
	logic             prev2_reg;
	logic             prev2_next;
	logic             edge_ok_reg;
	logic             edge_ok_next;
	logic             fnoise_reg;
	logic             fnoise_next;
	logic             hidden_reg;
	logic             hidden_next;
	logic [7:0]       shift_next;
	logic [7:0]       shift_q;
	urxe_frame_type   frame_reg;
	urxe_frame_type   frame_next;

	// Sampler next state; sixteen ticks per bit, vote at 8/9/10
	always_comb
	begin
		state_next   = state_reg;
		smp_next     = smp_reg;
		bit_next     = bit_reg;
		vote_next    = vote_reg;
		prev_next    = prev_reg;
		prev2_next   = prev2_reg;
		edge_ok_next = edge_ok_reg;
		fnoise_next  = fnoise_reg;
		hidden_next  = hidden_reg;
		shift_next   = shift_q;
		frame_next   = '0;
		if (tick)
		begin
			prev_next = line_s;
			prev2_next = prev_reg;
			smp_next  = smp_reg + 1'b1; // RULE15
			if (smp_reg + 1'b1 == SMP_A)
				vote_next[2] = line_s; // RULE6
			if (smp_reg + 1'b1 == SMP_B)
				vote_next[1] = line_s;
			if (smp_reg + 1'b1 == SMP_C)
				vote_next[0] = line_s;
			unique case (state_reg)
				URXE_IDLE:
				begin
					smp_next = SMP_ZERO;
					// High-to-low seen between two ticks starts the start bit
					if (prev_reg && !line_s)
					begin
						state_next   = URXE_START;
						smp_next     = 4'h1;
						// Valid only if high two ticks back too
						edge_ok_next = prev2_reg; // RULE7
						fnoise_next  = 1'b0;
					end
				end
				URXE_START:
				begin
					if (smp_reg == SMP_LAST)
					begin
						if (!urxe_agree(vote_reg))
						begin
							// False start: drop the frame, keep noise hidden
							state_next  = URXE_IDLE; // RULE12
							hidden_next = 1'b1; // RULE13
						end
						else if (vote_reg != 3'b000)
							state_next = URXE_IDLE; // Clean high: not a start
						else
						begin
							state_next = URXE_DATA;
							bit_next   = '0;
							// Clean low after a doubtful edge: noisy
							if (!edge_ok_reg)
								fnoise_next = 1'b1; // RULE7
						end
					end
				end
				URXE_DATA:
				begin
					if (smp_reg == SMP_LAST)
					begin
						if (!urxe_agree(vote_reg))
							fnoise_next = 1'b1; // RULE6
						// Sample 9 carries the bit; 8 and 10 vote
						// LSB first; the shift reg is always overwritten
						shift_next = {vote_reg[1], shift_q[7:1]}; // RULE3
						bit_next   = bit_reg + 1'b1;
						if (bit_reg + 1'b1 == BIT_LAST)
							state_next = URXE_STOP;
					end
				end
				URXE_STOP:
				begin
					if (smp_reg == SMP_LAST)
					begin
						// Frame ends; noise includes any hidden false start
						// Stop bit votes count towards noise too
						state_next = URXE_IDLE;
						frame_next.done  = 1'b1;
						frame_next.noisy = fnoise_reg | hidden_reg
							| !urxe_agree(vote_reg); // RULE14
						frame_next.data  = shift_q;
						hidden_next      = 1'b0;
					end
				end
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_reg   <= URXE_IDLE;
			smp_reg     <= SMP_ZERO;
			bit_reg     <= '0;
			vote_reg    <= 3'b111;
			prev_reg    <= 1'b1;
			prev2_reg   <= 1'b1;
			edge_ok_reg <= 1'b0;
			fnoise_reg  <= 1'b0;
			hidden_reg  <= 1'b0;
			shift_q     <= '0;
			frame_reg   <= '0;
		end
		else
		begin
			state_reg   <= state_next;
			smp_reg     <= smp_next;
			bit_reg     <= bit_next;
			vote_reg    <= vote_next;
			prev_reg    <= prev_next;
			prev2_reg   <= prev2_next;
			edge_ok_reg <= edge_ok_next;
			fnoise_reg  <= fnoise_next;
			hidden_reg  <= hidden_next;
			shift_q     <= shift_next;
			frame_reg   <= frame_next;
		end
	end

	// ----------------------------------------------------------------
	// Flags, holding register and interrupt
	// ----------------------------------------------------------------
	logic [7:0]     hold_reg;
	logic [7:0]     hold_next;
	urxe_flags_type flag_reg;
	urxe_flags_type flag_next;
	logic           armed_or_reg;
	logic           armed_or_next;
	logic           armed_nf_reg;
	logic           armed_nf_next;
	logic           irq_reg;
	logic           irq_next;

	// Overrun frames leave noise_flag alone: it describes the held byte
	// Clearing overrun_flag and noise_flag is a two-step sequence; a new frame wins over a same-cycle clear of any flag that it sets
	always_comb
	begin
		flag_next     = flag_reg;
		hold_next     = hold_reg;
		armed_or_next = armed_or_reg;
		armed_nf_next = armed_nf_reg;
		// Data read completes a clear that a status access armed
		if (sw_access.data_read)
		begin
			flag_next.rx_full_flag = 1'b0;
			if (armed_or_reg)
				flag_next.overrun_flag = 1'b0; // RULE5
			if (armed_nf_reg)
				flag_next.noise_flag = 1'b0; // RULE11
			armed_or_next = 1'b0;
			armed_nf_next = 1'b0;
		end
		// Status access arms the clear (read of a flag that is set)
		if (sw_access.status_access)
		begin
			armed_or_next = flag_reg.overrun_flag;
			armed_nf_next = flag_reg.noise_flag;
		end
		if (frame_reg.done)
		begin
			if (flag_reg.rx_full_flag)
				flag_next.overrun_flag = 1'b1; // RULE1 RULE3
			else
			begin
				// Noise, data and full flag appear together
				hold_next              = frame_reg.data; // RULE2 RULE9
				flag_next.rx_full_flag = 1'b1;
				flag_next.noise_flag   = frame_reg.noisy; // RULE8
			end
		end
		// Interrupt level: full flag or overrun, gated by enable and mask
		irq_next = rx_int_enable && !int_mask_bit
			&& (flag_next.rx_full_flag || flag_next.overrun_flag); // RULE4 RULE10
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			hold_reg     <= '0;
			flag_reg     <= '0;
			armed_or_reg <= 1'b0;
			armed_nf_reg <= 1'b0;
			irq_reg      <= 1'b0;
		end
		else
		begin
			hold_reg     <= hold_next;
			flag_reg     <= flag_next;
			armed_or_reg <= armed_or_next;
			armed_nf_reg <= armed_nf_next;
			irq_reg      <= irq_next;
		end
	end

	// Every output comes straight from a register
	assign flags           = flag_reg;
	assign serial_data_reg = hold_reg;
	assign shift_reg       = shift_q;
	assign rx_irq          = irq_reg;

endmodule

// [hw/urxe_pkg.sv]
/*
 Package for the receive error detection block: timing constants, sample
 positions, the bit-sampler state enum and the carrier structs.
 Assumes a single 25 MHz clock and a sixteen-times oversample tick.
*/
package urxe_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_HZ       = 25000000;
	localparam int unsigned BAUD_DEFAULT = 9600;
	localparam int unsigned OVS_PER_BIT  = 16;
	localparam int unsigned TICK_DIV     = CLK_HZ / (BAUD_DEFAULT * OVS_PER_BIT);
	localparam int unsigned DIV_W        = 16;
	localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_DIV - 1);

	// ----------------------------------------------------------------
	// Sample positions within one bit (counted 1..16)
	// ----------------------------------------------------------------
	localparam logic [3:0] SMP_A    = 4'h8;
	localparam logic [3:0] SMP_B    = 4'h9;
	localparam logic [3:0] SMP_C    = 4'ha;
	localparam logic [3:0] SMP_LAST = 4'hf;
	localparam logic [3:0] SMP_ZERO = 4'h0;

	// ----------------------------------------------------------------
	// Frame shape
	// ----------------------------------------------------------------
	localparam int unsigned DATA_BITS = 8;
	localparam logic [3:0]  BIT_LAST  = 4'h8; // Data bits 0..7, stop is 8

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		URXE_IDLE,
		URXE_START,
		URXE_DATA,
		URXE_STOP
	} urxe_state_type;

	// One finished frame handed from the sampler to the flag logic
	typedef struct packed {
		logic                 done;
		logic                 noisy;
		logic [DATA_BITS-1:0] data;
	} urxe_frame_type;

	// Software side accesses
	typedef struct packed {
		logic status_access;
		logic data_read;
	} urxe_access_type;

	// Flags seen by software
	typedef struct packed {
		logic rx_full_flag;
		logic overrun_flag;
		logic noise_flag;
	} urxe_flags_type;

	// Majority-free vote: true only when all three samples are equal
	function automatic logic urxe_agree(input logic [2:0] s);
		return (s == 3'b000) || (s == 3'b111);
	endfunction

endpackage

// [hw/urxe_sync.sv]
/*
 Two flip-flop synchroniser for the serial line input.
 Assumes the line idles high, so both stages reset to one.
*/
`timescale 1ns/10ps
module urxe_sync
(
	// Clock and reset
	input  wire logic mclk,
	input  wire logic rst_n,
	// Line
	input  wire logic din,
	output logic      dout
);

	logic meta_reg;
	logic meta_next;
	logic dout_reg;
	logic dout_next;

	// Next values: first stage feeds only the second
	always_comb
	begin
		meta_next = din;
		dout_next = meta_reg;
	end

	// Registers
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta_reg <= 1'b1;
			dout_reg <= 1'b1;
		end
		else
		begin
			meta_reg <= meta_next;
			dout_reg <= dout_next;
		end
	end

	assign dout = dout_reg;

endmodule

// [hw/urxe_tick.sv]
/*
 Oversample tick generator: one-cycle pulse every div_last+1 clocks.
 Assumes the divider value is held steady by the system.
*/
`timescale 1ns/10ps
module urxe_tick
(
	// Clock and reset
	input  wire logic                     mclk,
	input  wire logic                     rst_n,
	// Divider and tick
	input  wire logic [urxe_pkg::DIV_W-1:0] div_last,
	output logic                          tick
);
	import urxe_pkg::*;

	logic [DIV_W-1:0] cnt_reg;
	logic [DIV_W-1:0] cnt_next;
	logic             tick_reg;
	logic             tick_next;

	// Count down the divider, pulse on wrap
	always_comb
	begin
		tick_next = (cnt_reg == '0);
		cnt_next  = tick_next ? div_last : cnt_reg - 1'b1;
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt_reg  <= '0;
			tick_reg <= 1'b0;
		end
		else
		begin
			cnt_reg  <= cnt_next;
			tick_reg <= tick_next;
		end
	end

	assign tick = tick_reg;

endmodule

// [verif/urxe_rx_sva.sv]
/*
 Checker for urxe_rx: flag, held data and interrupt relations.
 Assumes it is bound to urxe_rx and sees only that module's ports.
*/
`timescale 1ns/10ps
module urxe_rx_sva
(
	// Clock and reset
	input wire logic                       mclk,
	input wire logic                       rst_n,
	// Configuration and accesses
	input wire logic                       rx_int_enable,
	input wire logic                       int_mask_bit,
	input wire urxe_pkg::urxe_access_type  sw_access,
	// Outputs under watch
	input wire urxe_pkg::urxe_flags_type   flags,
	input wire logic [7:0]                 serial_data_reg,
	input wire logic                       rx_irq
);
	import urxe_pkg::*;
	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);
	logic any_flag;
	logic irq_off;
	// Irq is registered, so allow the source one cycle of lag
	assign any_flag = flags.rx_full_flag | flags.overrun_flag;
	assign irq_off = !rx_int_enable | int_mask_bit;
	a_noise_with_full: assert property ($rose(flags.noise_flag) |->
		$rose(flags.rx_full_flag)) else $error("noise rose alone");
	a_irq_gated: assert property (irq_off && $past(irq_off) |->
		!rx_irq) else $error("irq while gated");
	a_irq_source: assert property (rx_irq |->
		any_flag || $past(any_flag)) else $error("irq with no source");
	a_data_held: assert property (flags.rx_full_flag
		&& $past(flags.rx_full_flag) && !$past(sw_access.data_read)
		|-> $stable(serial_data_reg)) else $error("held byte moved");
	a_overrun_sets: assert property ($rose(flags.overrun_flag) |->
		$past(flags.rx_full_flag)) else $error("overrun without full");
	a_overrun_keeps: assert property ($rose(flags.overrun_flag) |->
		$stable(serial_data_reg)) else $error("overrun lost byte");
	a_overrun_clear: assert property ($fell(flags.overrun_flag) |->
		$past(sw_access.data_read)) else $error("overrun cleared early");
	a_noise_clear: assert property ($fell(flags.noise_flag) |->
		$past(sw_access.data_read)) else $error("noise cleared early");
	c_overrun: cover property ($rose(flags.overrun_flag));
	c_noise: cover property ($rose(flags.noise_flag));
	c_irq: cover property ($rose(rx_irq));
endmodule

bind urxe_rx urxe_rx_sva u_sva
(
	.mclk            (mclk),
	.rst_n           (rst_n),
	.rx_int_enable   (rx_int_enable),
	.int_mask_bit    (int_mask_bit),
	.sw_access       (sw_access),
	.flags           (flags),
	.serial_data_reg (serial_data_reg),
	.rx_irq          (rx_irq)
);

// [verif/urxe_tx_model.sv]
/*
 Remote transmitter: sends 8N1 frames, optionally with a glitch.
 Assumes one bit lasts sixteen mclk cycles (tick every clock).
*/
`timescale 1ns/10ps
module urxe_tx_model
(
	// Clock
	input  wire logic mclk,
	// Serial line, driven high when idle
	output logic      line
);
	initial line = 1'b1;
	// Drive a level for n cycles, changing only on falling edges
	task automatic hold(input logic v, input int n);
		line = v;
		repeat (n) @(negedge mclk);
	endtask
	// Mode 0 clean, 1 glitch mid bit 3, 2 short false start
	task automatic send(input logic [7:0] b, input int mode);
		@(negedge mclk);
		if (mode == 2)
		begin
			hold(1'b0, 9); // Low too short for the mid-bit vote
			hold(1'b1, 40);
		end
		else
		begin
			hold(1'b0, 16);
			for (int i = 0; i < 8; i++)
			begin
				hold(b[i], (mode == 1 && i == 3) ? 9 : 16);
				if (mode == 1 && i == 3)
				begin
					// Glitch on sample 10 only; sample 9 keeps the bit
					hold(!b[i], 1);
					hold(b[i], 6);
				end
			end
			hold(1'b1, 16);
		end
	endtask
endmodule

// [verif/urxe_rx_bench.sv]
/*
 Self-checking bench for urxe_rx with a transmitter model on the line.
 Assumes a tick every clock, so a frame lasts 160 cycles.
*/
`timescale 1ns/10ps
module urxe_rx_bench;
	import urxe_pkg::*;
	// ----------------------------------------------------------------
	// Signals, clock and instances
	// ----------------------------------------------------------------
	logic             mclk = 1'b0;
	logic             rst_n;
	logic             rx_line;
	logic [DIV_W-1:0] baud_div_last;
	logic             rx_int_enable;
	logic             int_mask_bit;
	urxe_access_type  sw_access;
	urxe_flags_type   flags;
	logic [7:0]       serial_data_reg;
	logic [7:0]       shift_reg;
	logic             rx_irq;
	int               failures = 0;
	int               compares = 0;
	always #20 mclk = ~mclk;
	urxe_rx u_dut (.mclk(mclk), .rst_n(rst_n), .rx_line(rx_line),
		.baud_div_last(baud_div_last), .rx_int_enable(rx_int_enable),
		.int_mask_bit(int_mask_bit), .sw_access(sw_access), .flags(flags),
		.serial_data_reg(serial_data_reg), .shift_reg(shift_reg),
		.rx_irq(rx_irq));
	urxe_tx_model u_tx (.mclk(mclk), .line(rx_line));
	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic tally_and_finish;
		if (failures == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp)
		begin
			failures++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// One-cycle software strobes, settled before and after
	task automatic pulse(input logic st, input logic rd);
		@(negedge mclk);
		sw_access = {st, rd};
		@(negedge mclk);
		sw_access = '0;
		repeat (2) @(negedge mclk);
	endtask
	// Bounded wait for a delivered frame
	task automatic wait_full;
		int n = 0;
		while (flags.rx_full_flag !== 1'b1 && n < 400)
		begin
			@(negedge mclk);
			n++;
		end
		if (n == 400)
		begin
			failures++;
			tally_and_finish();
		end
	endtask
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic sc_clean;
		u_tx.send(8'ha5, 0);
		wait_full();
		chk(serial_data_reg, 8'ha5);
		chk({5'h0, flags}, 8'h04);
		chk({7'h0, rx_irq}, 8'h01);
		pulse(1'b1, 1'b0);
		pulse(1'b0, 1'b1);
		chk({4'h0, flags, rx_irq}, 8'h00);
	endtask
	task automatic sc_noise;
		u_tx.send(8'h5a, 1);
		wait_full();
		chk({5'h0, flags}, 8'h05);
		chk(serial_data_reg, 8'h5a);
		pulse(1'b0, 1'b1);
		chk({5'h0, flags}, 8'h01);
		pulse(1'b1, 1'b0);
		pulse(1'b0, 1'b1);
		chk({5'h0, flags}, 8'h00);
	endtask
	task automatic sc_overrun;
		int_mask_bit = 1'b1;
		u_tx.send(8'h3c, 0);
		wait_full();
		u_tx.send(8'hc3, 0);
		repeat (20) @(negedge mclk);
		chk({5'h0, flags}, 8'h06);
		chk(serial_data_reg, 8'h3c);
		chk(shift_reg, 8'hc3);
		chk({7'h0, rx_irq}, 8'h00);
		int_mask_bit = 1'b0;
		repeat (3) @(negedge mclk);
		chk({7'h0, rx_irq}, 8'h01);
		rx_int_enable = 1'b0;
		repeat (3) @(negedge mclk);
		chk({7'h0, rx_irq}, 8'h00);
		rx_int_enable = 1'b1;
		pulse(1'b0, 1'b1);
		chk({5'h0, flags}, 8'h02);
		pulse(1'b1, 1'b0);
		pulse(1'b0, 1'b1);
		chk({4'h0, flags, rx_irq}, 8'h00);
	endtask
	task automatic sc_false_start;
		u_tx.send(8'h00, 2);
		chk({5'h0, flags}, 8'h00);
		u_tx.send(8'h81, 0);
		wait_full();
		chk({5'h0, flags}, 8'h05);
		chk(serial_data_reg, 8'h81);
		pulse(1'b1, 1'b0);
		pulse(1'b0, 1'b1);
	endtask
	initial
	begin
		rst_n = 1'b0;
		baud_div_last = '0;
		rx_int_enable = 1'b1;
		int_mask_bit = 1'b0;
		sw_access = '0;
		repeat (12) @(negedge mclk);
		rst_n = 1'b1;
		repeat (4) @(negedge mclk);
		sc_clean();
		sc_noise();
		sc_overrun();
		sc_false_start();
		tally_and_finish();
	end
endmodule
